// ---- rtl/tsw_pkg.sv ----
package tsw_pkg;

    // Bus side clock and conversion periods
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CONV_MS_0 = 4000;
    localparam int unsigned CONV_MS_1 = 1000;
    localparam int unsigned CONV_MS_2 = 250;
    localparam int unsigned CONV_MS_3 = 125;
    localparam int unsigned CONV_CYC_0 = CONV_MS_0 * (CLK_HZ / 1000);
    localparam int unsigned CONV_CYC_1 = CONV_MS_1 * (CLK_HZ / 1000);
    localparam int unsigned CONV_CYC_2 = CONV_MS_2 * (CLK_HZ / 1000);
    localparam int unsigned CONV_CYC_3 = CONV_MS_3 * (CLK_HZ / 1000);

    // APB register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TEMP = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam int CTRL_RATE_LSB = 0;
    localparam int STATUS_COUNT_LSB = 0;
    localparam int STATUS_BUSY_BIT = 8;
    localparam logic [1:0] RATE_RESET = 2'h0;
    localparam logic [7:0] TEMP_RESET = 8'h00;

    // Serial port
    localparam logic [3:0] DEV_ADDR_HI = 4'h9;
    localparam logic [6:0] GLOBAL_ADDR = 7'h6A;
    localparam logic [7:0] PTR_TEMP = 8'h00;
    localparam logic [7:0] PTR_CONFIG = 8'h01;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_WR_BYTE = 3'b011,
        ST_WR_ACK = 3'b100,
        ST_RD_BYTE = 3'b101,
        ST_RD_ACK = 3'b110
    } tsw_state_e;

endpackage

// ---- rtl/tsw_word_sync.sv ----
`timescale 1ns/1ps
module tsw_word_sync #(
    parameter int W = 8
) (
    input wire logic srcClock,
    input wire logic srcRst_n,
    input wire logic srcValid,
    input wire logic [W-1:0] srcData,
    output logic srcBusy,
    input wire logic dstClock,
    input wire logic dstRst_n,
    output logic dstValid,
    output logic [W-1:0] dstData
);
    logic reqT_ff;
    logic ackS1_ff;
    logic ackS2_ff;
    logic [W-1:0] hold_ff;
    logic reqS1_ff;
    logic reqS2_ff;
    logic reqS3_ff;
    logic ackT_ff;
    logic dstValid_ff;
    logic [W-1:0] dstData_ff;

    // Held word stays still until the echo returns
    assign srcBusy = reqT_ff ^ ackS2_ff;
    assign dstValid = dstValid_ff;
    assign dstData = dstData_ff;

    always_ff @(posedge srcClock or negedge srcRst_n) begin
        if (!srcRst_n) begin
            reqT_ff <= 1'b0;
            hold_ff <= '0;
        end else if (srcValid && !srcBusy) begin
            reqT_ff <= ~reqT_ff;
            hold_ff <= srcData;
        end
    end

    always_ff @(posedge srcClock or negedge srcRst_n) begin
        if (!srcRst_n) begin
            ackS1_ff <= 1'b0;
            ackS2_ff <= 1'b0;
        end else begin
            ackS1_ff <= ackT_ff;
            ackS2_ff <= ackS1_ff;
        end
    end

    always_ff @(posedge dstClock or negedge dstRst_n) begin
        if (!dstRst_n) begin
            reqS1_ff <= 1'b0;
            reqS2_ff <= 1'b0;
            reqS3_ff <= 1'b0;
            ackT_ff <= 1'b0;
            dstValid_ff <= 1'b0;
            dstData_ff <= '0;
        end else begin
            reqS1_ff <= reqT_ff;
            reqS2_ff <= reqS1_ff;
            reqS3_ff <= reqS2_ff;
            ackT_ff <= reqS2_ff;
            dstValid_ff <= reqS2_ff ^ reqS3_ff;
            if (reqS2_ff ^ reqS3_ff) begin
                dstData_ff <= hold_ff;
            end
        end
    end
endmodule

// ---- rtl/tsw_sensor_port.sv ----
`timescale 1ns/1ps
// How it works
// - Conversion pulses at 0.25, 1, 4 or 8 per second by rate bits.
// - Oversampled port handles fast and high-speed SCL rates.
// - Idle bus has SDA released; slave rests in idle state.
// - SDA falling while SCL high starts a transaction.
// - STOP or repeated START ends the current transfer.
// - Receiver drives SDA low through the whole ninth clock.
// - Low three address bits come from a fixed variant parameter.
// - Global write is acknowledged by every sensor simultaneously.
// - Global read serves up to eight sensors in fixed turns.
// - Rate bits live in configuration, setting conversion spacing.
module tsw_sensor_port #(
    parameter logic [2:0] VARIANT_ADDR = 3'h0,
    parameter int unsigned CONV_CYC_0 = tsw_pkg::CONV_CYC_0,
    parameter int unsigned CONV_CYC_1 = tsw_pkg::CONV_CYC_1,
    parameter int unsigned CONV_CYC_2 = tsw_pkg::CONV_CYC_2,
    parameter int unsigned CONV_CYC_3 = tsw_pkg::CONV_CYC_3
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic convStart,
    input wire logic linkClock,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);
    import tsw_pkg::*;

    function automatic logic [31:0] periodFor(input logic [1:0] rate);
        case (rate)
            2'h0: periodFor = CONV_CYC_0;
            2'h1: periodFor = CONV_CYC_1;
            2'h2: periodFor = CONV_CYC_2;
            default: periodFor = CONV_CYC_3;
        endcase
    endfunction

    function automatic logic turnFor(input logic multi_device_access, input logic [2:0] idx);
        turnFor = !multi_device_access || (idx == VARIANT_ADDR);
    endfunction

    // Bus clock domain
    logic [1:0] rate_ff;
    logic [7:0] temp_ff;
    logic [31:0] periodCnt_ff;
    logic convStart_ff;
    logic [7:0] convCount_ff;
    logic ready_ff;
    logic slvErr_ff;
    logic [31:0] rdata_ff;
    logic [9:0] lastSent_ff;
    logic mapped;
    logic apbWrite;
    logic [31:0] readMux;
    logic upBusy;
    logic upValid;
    logic cfgInValid;
    logic [1:0] cfgInData;

    // Link clock domain
    logic linkRs1_ff;
    logic linkRstN_ff;
    logic sclS1_ff;
    logic sclS2_ff;
    logic sclS3_ff;
    logic sdaS1_ff;
    logic sdaS2_ff;
    logic sdaS3_ff;
    tsw_state_e state_ff;
    logic [3:0] bitCnt_ff;
    logic [7:0] rxShift_ff;
    logic [7:0] txShift_ff;
    logic sdaOe_ff;
    logic sdaOut_ff;
    logic isRead_ff;
    logic mdaRead_ff;
    logic myTurn_ff;
    logic firstByte_ff;
    logic [2:0] byteIdx_ff;
    logic [7:0] pointer_ff;
    logic cfgWrValid_ff;
    logic [1:0] cfgWrData_ff;
    logic [9:0] linkView;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic devHit;
    logic mdaHit;
    logic addrHit;
    logic [7:0] readByte;

    assign prdata = rdata_ff;
    assign pready = ready_ff;
    assign pslverr = slvErr_ff;
    assign convStart = convStart_ff;
    assign sdaOe = sdaOe_ff;
    assign sdaOut = sdaOut_ff;

    // APB slave, one wait-free access phase
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_TEMP) || (paddr == REG_STATUS);
    assign apbWrite = psel && penable && pwrite && ready_ff && mapped;

    always_comb begin
        readMux = 32'h0000_0000;
        case (paddr)
            REG_CTRL: readMux[CTRL_RATE_LSB +: 2] = rate_ff;
            REG_TEMP: readMux[7:0] = temp_ff;
            REG_STATUS: begin
                readMux[STATUS_COUNT_LSB +: 8] = convCount_ff;
                readMux[STATUS_BUSY_BIT] = upBusy;
            end
            default: readMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready_ff <= 1'b0;
            slvErr_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            ready_ff <= psel && !penable;
            slvErr_ff <= psel && !penable && !mapped;
            rdata_ff <= (psel && !penable && !pwrite) ? readMux : 32'h0000_0000;
        end
    end

    // Software write wins over a serial write landing in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rate_ff <= RATE_RESET;
            temp_ff <= TEMP_RESET;
        end else begin
            if (apbWrite && paddr == REG_CTRL) begin
                rate_ff <= pwdata[CTRL_RATE_LSB +: 2];
            end else if (cfgInValid) begin
                rate_ff <= cfgInData;
            end
            if (apbWrite && paddr == REG_TEMP) begin
                temp_ff <= pwdata[7:0];
            end
        end
    end

    // Period timer; zero after reset so the first conversion starts at once
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            periodCnt_ff <= 32'h0000_0000;
            convStart_ff <= 1'b0;
            convCount_ff <= 8'h00;
        end else begin
            convStart_ff <= (periodCnt_ff == 32'h0000_0000);
            if (periodCnt_ff == 32'h0000_0000) begin
                periodCnt_ff <= periodFor(rate_ff) - 32'h0000_0001;
                convCount_ff <= convCount_ff + 8'h01;
            end else begin
                periodCnt_ff <= periodCnt_ff - 32'h0000_0001;
            end
        end
    end

    rate_period_a: assert property (@(posedge clock) disable iff (!rst_n)
        (periodCnt_ff == 32'h0000_0000) |=> convStart_ff
            && periodCnt_ff == periodFor($past(rate_ff)) - 32'h0000_0001)
        else $error("conversion period does not follow rate bits");

    // Resend config and temperature whenever they differ from the link copy
    assign upValid = {rate_ff, temp_ff} != lastSent_ff;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lastSent_ff <= {RATE_RESET, TEMP_RESET};
        end else if (upValid && !upBusy) begin
            lastSent_ff <= {rate_ff, temp_ff};
        end
    end

    tsw_word_sync #(.W(10)) upSync (
        .srcClock(clock),
        .srcRst_n(rst_n),
        .srcValid(upValid),
        .srcData({rate_ff, temp_ff}),
        .srcBusy(upBusy),
        .dstClock(linkClock),
        .dstRst_n(linkRstN_ff),
        .dstValid(),
        .dstData(linkView)
    );

    tsw_word_sync #(.W(2)) downSync (
        .srcClock(linkClock),
        .srcRst_n(linkRstN_ff),
        .srcValid(cfgWrValid_ff),
        .srcData(cfgWrData_ff),
        .srcBusy(),
        .dstClock(clock),
        .dstRst_n(rst_n),
        .dstValid(cfgInValid),
        .dstData(cfgInData)
    );

    // Link reset released in step with the link clock
    always_ff @(posedge linkClock or negedge rst_n) begin
        if (!rst_n) begin
            linkRs1_ff <= 1'b0;
            linkRstN_ff <= 1'b0;
        end else begin
            linkRs1_ff <= 1'b1;
            linkRstN_ff <= linkRs1_ff;
        end
    end

    // Pins sampled by a fast link clock; needs two samples per SCL high phase
    always_ff @(posedge linkClock or negedge linkRstN_ff) begin
        if (!linkRstN_ff) begin
            sclS1_ff <= 1'b1;
            sclS2_ff <= 1'b1;
            sclS3_ff <= 1'b1;
            sdaS1_ff <= 1'b1;
            sdaS2_ff <= 1'b1;
            sdaS3_ff <= 1'b1;
        end else begin
            sclS1_ff <= scl;
            sclS2_ff <= sclS1_ff;
            sclS3_ff <= sclS2_ff;
            sdaS1_ff <= sdaIn;
            sdaS2_ff <= sdaS1_ff;
            sdaS3_ff <= sdaS2_ff;
        end
    end

    assign sclRise = sclS2_ff && !sclS3_ff;
    assign sclFall = !sclS2_ff && sclS3_ff;
    assign startSeen = sclS2_ff && sclS3_ff && sdaS3_ff && !sdaS2_ff;
    assign stopSeen = sclS2_ff && sclS3_ff && !sdaS3_ff && sdaS2_ff;
    assign devHit = rxShift_ff[7:1] == {DEV_ADDR_HI, VARIANT_ADDR};
    assign mdaHit = rxShift_ff[7:1] == GLOBAL_ADDR;
    assign addrHit = devHit || mdaHit;
    assign readByte = (pointer_ff == PTR_TEMP) ? linkView[7:0]
        : (pointer_ff == PTR_CONFIG) ? {6'h00, linkView[9:8]} : 8'h00;

    always_ff @(posedge linkClock or negedge linkRstN_ff) begin
        if (!linkRstN_ff) begin
            state_ff <= ST_IDLE;
            bitCnt_ff <= 4'h0;
            rxShift_ff <= 8'h00;
            txShift_ff <= 8'h00;
            sdaOe_ff <= 1'b0;
            sdaOut_ff <= 1'b0;
            isRead_ff <= 1'b0;
            mdaRead_ff <= 1'b0;
            myTurn_ff <= 1'b0;
            firstByte_ff <= 1'b0;
            byteIdx_ff <= 3'h0;
            pointer_ff <= PTR_TEMP;
            cfgWrValid_ff <= 1'b0;
            cfgWrData_ff <= RATE_RESET;
        end else begin
            cfgWrValid_ff <= 1'b0;
            if (startSeen) begin
                state_ff <= ST_ADDR;
                bitCnt_ff <= 4'h0;
                sdaOe_ff <= 1'b0;
            end else if (stopSeen) begin
                state_ff <= ST_IDLE;
                sdaOe_ff <= 1'b0;
            end else begin
                if (sclRise && state_ff != ST_IDLE) begin
                    rxShift_ff <= {rxShift_ff[6:0], sdaS2_ff};
                    bitCnt_ff <= bitCnt_ff + 4'h1;
                    if (state_ff == ST_RD_ACK && sdaS2_ff) begin
                        state_ff <= ST_IDLE;
                    end
                end
                if (sclFall) begin
                    case (state_ff)
                        ST_ADDR: begin
                            if (bitCnt_ff == BITS_PER_BYTE) begin
                                bitCnt_ff <= 4'h0;
                                if (addrHit) begin
                                    state_ff <= ST_ADDR_ACK;
                                    sdaOe_ff <= 1'b1;
                                    isRead_ff <= rxShift_ff[0];
                                    mdaRead_ff <= mdaHit && rxShift_ff[0];
                                end else begin
                                    state_ff <= ST_IDLE;
                                end
                            end
                        end
                        ST_ADDR_ACK: begin
                            bitCnt_ff <= 4'h0;
                            byteIdx_ff <= 3'h0;
                            if (isRead_ff) begin
                                state_ff <= ST_RD_BYTE;
                                txShift_ff <= readByte;
                                myTurn_ff <= turnFor(mdaRead_ff, 3'h0);
                                sdaOe_ff <= !readByte[7] && turnFor(mdaRead_ff, 3'h0);
                            end else begin
                                state_ff <= ST_WR_BYTE;
                                firstByte_ff <= 1'b1;
                                sdaOe_ff <= 1'b0;
                            end
                        end
                        ST_WR_BYTE: begin
                            if (bitCnt_ff == BITS_PER_BYTE) begin
                                bitCnt_ff <= 4'h0;
                                state_ff <= ST_WR_ACK;
                                sdaOe_ff <= 1'b1;
                                firstByte_ff <= 1'b0;
                                if (firstByte_ff) begin
                                    pointer_ff <= rxShift_ff;
                                end else if (pointer_ff == PTR_CONFIG) begin
                                    cfgWrValid_ff <= 1'b1;
                                    cfgWrData_ff <= rxShift_ff[1:0];
                                end
                            end
                        end
                        ST_WR_ACK: begin
                            // Bytes keep coming until the master ends the frame
                            state_ff <= ST_WR_BYTE;
                            bitCnt_ff <= 4'h0;
                            sdaOe_ff <= 1'b0;
                        end
                        ST_RD_BYTE: begin
                            if (bitCnt_ff == BITS_PER_BYTE) begin
                                state_ff <= ST_RD_ACK;
                                sdaOe_ff <= 1'b0;
                            end else begin
                                txShift_ff <= {txShift_ff[6:0], 1'b0};
                                sdaOe_ff <= !txShift_ff[6] && myTurn_ff;
                            end
                        end
                        ST_RD_ACK: begin
                            // Reached only after a master acknowledge
                            state_ff <= ST_RD_BYTE;
                            bitCnt_ff <= 4'h0;
                            byteIdx_ff <= byteIdx_ff + 3'h1;
                            txShift_ff <= readByte;
                            myTurn_ff <= turnFor(mdaRead_ff, byteIdx_ff + 3'h1);
                            sdaOe_ff <= !readByte[7] && turnFor(mdaRead_ff, byteIdx_ff + 3'h1);
                        end
                        default: begin
                            sdaOe_ff <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end

    idle_release_a: assert property (@(posedge linkClock) disable iff (!linkRstN_ff)
        (state_ff == ST_IDLE) |-> !sdaOe_ff)
        else $error("SDA driven while idle");

    start_detect_a: assert property (@(posedge linkClock) disable iff (!linkRstN_ff)
        startSeen |=> state_ff == ST_ADDR && bitCnt_ff == 4'h0 && !sdaOe_ff)
        else $error("START not taken");

    stop_detect_a: assert property (@(posedge linkClock) disable iff (!linkRstN_ff)
        stopSeen && !startSeen |=> state_ff == ST_IDLE)
        else $error("STOP not taken");

    ack_drive_a: assert property (@(posedge linkClock) disable iff (!linkRstN_ff)
        sclFall && !startSeen && !stopSeen && bitCnt_ff == BITS_PER_BYTE
            && (state_ff == ST_WR_BYTE || (state_ff == ST_ADDR && addrHit))
        |=> sdaOe_ff && (state_ff == ST_WR_ACK || state_ff == ST_ADDR_ACK))
        else $error("no acknowledge driven");

    addr_match_a: assert property (@(posedge linkClock) disable iff (!linkRstN_ff)
        sclFall && !startSeen && !stopSeen && state_ff == ST_ADDR
            && bitCnt_ff == BITS_PER_BYTE && !addrHit
        |=> state_ff == ST_IDLE ##1 !sdaOe_ff)
        else $error("foreign address acknowledged");

    mda_turn_a: assert property (@(posedge linkClock) disable iff (!linkRstN_ff)
        (state_ff == ST_RD_BYTE && mdaRead_ff && byteIdx_ff != VARIANT_ADDR) |-> !sdaOe_ff)
        else $error("SDA driven outside own turn");

    msb_first_a: assert property (@(posedge linkClock) disable iff (!linkRstN_ff)
        (state_ff == ST_RD_BYTE && sdaOe_ff) |-> !txShift_ff[7] && myTurn_ff)
        else $error("data bit out of order");

    sda_change_a: assert property (@(posedge linkClock) disable iff (!linkRstN_ff)
        $changed(sdaOe_ff) |-> $past(sclFall) || $past(startSeen) || $past(stopSeen))
        else $error("SDA changed while SCL high");

    nack_release_a: assert property (@(posedge linkClock) disable iff (!linkRstN_ff)
        sclRise && !startSeen && !stopSeen && state_ff == ST_RD_ACK && sdaS2_ff
        |=> state_ff == ST_IDLE [*2])
        else $error("read not ended by not-acknowledge");

endmodule

// ---- bench/tsw_bus_master.sv ----
`timescale 1ns/1ps
module tsw_bus_master #(
    parameter int HALF = 200
) (
    output logic scl,
    output logic sdaLow,
    input wire logic sda
);
    // Both lines released while idle
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic startc();
        sdaLow = 1'b0;
        #HALF scl = 1'b1;
        #HALF sdaLow = 1'b1;
        #HALF scl = 1'b0;
        #HALF;
    endtask
    task automatic stopc();
        sdaLow = 1'b1;
        #HALF scl = 1'b1;
        #HALF sdaLow = 1'b0;
        #HALF;
    endtask
    // Data moves only in the low phase, with hold after the fall
    task automatic bitx(input logic b, output logic r);
        sdaLow = ~b;
        #HALF scl = 1'b1;
        #HALF r = sda;
        scl = 1'b0;
        #(HALF/2);
    endtask
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, ack);
    endtask
    task automatic getByte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(nack, r);
    endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import tsw_pkg::*;
    // Short periods keep the run small
    localparam int unsigned C0 = 400;
    localparam int unsigned C1 = 100;
    localparam int unsigned C2 = 25;
    localparam int unsigned C3 = 13;
    localparam logic [2:0] VAR = 3'h2;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic linkClock = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, convStart, scl, sdaLow, sdaOut, sdaOe, sdaLine;
    int fails = 0;
    int total_checks = 0;
    // Pull-up wins unless someone pulls low
    assign sdaLine = ~((sdaOe & ~sdaOut) | sdaLow);
    always #5 clock = ~clock;
    initial #7 forever #15 linkClock = ~linkClock;
    tsw_sensor_port #(.VARIANT_ADDR(VAR), .CONV_CYC_0(C0), .CONV_CYC_1(C1), .CONV_CYC_2(C2),
        .CONV_CYC_3(C3)) DUT (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .convStart(convStart), .linkClock(linkClock), .scl(scl),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
    tsw_bus_master mst (.scl(scl), .sdaLow(sdaLow), .sda(sdaLine));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic hang();
        fails++;
        $display("FAIL wait expected done seen timeout");
        stop_test();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) hang();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic expErr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        check(nm, r, exp);
        check({nm, " err"}, {31'h0, e}, {31'h0, expErr});
    endtask
    task automatic waitConv(output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (convStart !== 1'b1 && n < 1000);
        if (convStart !== 1'b1) hang();
    endtask
    task automatic sendChk(input logic [7:0] d, input logic expAck);
        logic a;
        mst.sendByte(d, a);
        check("ack bit", {31'h0, a}, {31'h0, expAck});
    endtask
    task automatic getChk(input logic nack, input logic [7:0] exp);
        logic [7:0] d;
        mst.getByte(nack, d);
        check("read byte", {24'h0, d}, {24'h0, exp});
    endtask
    task automatic regs_scn();
        rdChk("ctrl reset", REG_CTRL, 32'h0000_0000, 1'b0);
        rdChk("temp reset", REG_TEMP, 32'h0000_0000, 1'b0);
        wr(REG_TEMP, 32'hFFFF_FF5A);
        rdChk("temp", REG_TEMP, 32'h0000_005A, 1'b0);
        rdChk("unmapped", 8'h0C, 32'h0000_0000, 1'b1);
    endtask
    // Third pulse after a change is sure to use the new spacing
    task automatic rate_scn();
        int n;
        int unsigned per [4];
        per = '{C0, C1, C2, C3};
        for (int r = 3; r >= 0; r--) begin
            wr(REG_CTRL, 32'(r));
            repeat (3) waitConv(n);
            check("conv period", n, per[r]);
        end
    endtask
    task automatic swrite_scn();
        mst.startc();
        sendChk({DEV_ADDR_HI, VAR, 1'b0}, 1'b0);
        sendChk(PTR_CONFIG, 1'b0);
        sendChk(8'h03, 1'b0);
        sendChk(8'h01, 1'b0);
        mst.stopc();
        repeat (30) @(posedge clock);
        rdChk("ctrl serial", REG_CTRL, 32'h0000_0001, 1'b0);
        check("sda idle", {31'h0, sdaLine}, 32'h0000_0001);
        mst.startc();
        sendChk({DEV_ADDR_HI, ~VAR, 1'b0}, 1'b1);
        mst.stopc();
    endtask
    task automatic sread_scn();
        wr(REG_TEMP, 32'h0000_00A5);
        repeat (30) @(posedge clock);
        mst.startc();
        sendChk({DEV_ADDR_HI, VAR, 1'b0}, 1'b0);
        sendChk(PTR_TEMP, 1'b0);
        mst.startc();
        sendChk({DEV_ADDR_HI, VAR, 1'b1}, 1'b0);
        getChk(1'b0, 8'hA5);
        getChk(1'b1, 8'hA5);
        mst.stopc();
        check("sda drive", {31'h0, sdaOe}, 32'h0000_0000);
        check("sda value", {31'h0, sdaOut}, 32'h0000_0000);
    endtask
    task automatic global_scn();
        mst.startc();
        sendChk({GLOBAL_ADDR, 1'b0}, 1'b0);
        sendChk(PTR_CONFIG, 1'b0);
        sendChk(8'h02, 1'b0);
        mst.startc();
        sendChk({GLOBAL_ADDR, 1'b0}, 1'b0);
        sendChk(PTR_TEMP, 1'b0);
        mst.startc();
        sendChk({GLOBAL_ADDR, 1'b1}, 1'b0);
        for (int k = 0; k < 8; k++) begin
            getChk(k == 7, (k == VAR) ? 8'hA5 : 8'hFF);
        end
        mst.stopc();
        repeat (30) @(posedge clock);
        rdChk("ctrl global", REG_CTRL, 32'h0000_0002, 1'b0);
    endtask
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (10) @(posedge clock);
        regs_scn();
        rate_scn();
        swrite_scn();
        sread_scn();
        global_scn();
        stop_test();
    end
endmodule
